// ---- rtl/epfr_pkg.sv ----
// Package of offsets, field layout and types for the engine fault recorders
package epfr_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam int EPFR_ADDR_W = 20;
	localparam logic [EPFR_ADDR_W-1:0] EPFR_MEDIA_OFS = 20'h04194;
	localparam logic [EPFR_ADDR_W-1:0] EPFR_BLIT_OFS = 20'h04294;
	localparam logic [31:0] EPFR_RESET_VAL = 32'h0000_0000;

	// ************************************************************
	// Field layout
	// ************************************************************
	localparam int EPFR_VADDR_LSB = 12;
	localparam int EPFR_VADDR_W = 20;
	localparam int EPFR_TSEL_POS = 11;
	localparam int EPFR_REQUESTER_IDENTIFIER_LSB = 3;
	localparam int EPFR_REQUESTER_IDENTIFIER_W = 8;
	localparam int EPFR_CLASS_LSB = 1;
	localparam int EPFR_VALID_POS = 0;

	// Fault class encoding
	typedef enum logic [1:0] {
		EPFR_PAGE_FAULT = 2'h0,
		EPFR_PD_INVALID = 2'h1,
		EPFR_PD_UNLOADED = 2'h2,
		EPFR_PD_BOTH = 2'h3
	} epfr_class_e;

	// One fault report from the translation unit
	typedef struct packed {
		logic [EPFR_VADDR_W-1:0] vaddr;
		logic table_sel;
		logic [EPFR_REQUESTER_IDENTIFIER_W-1:0] requester_identifier;
		epfr_class_e fault_class;
	} epfr_fault_s;

	// Register access request: one read or write strobe per cycle
	typedef struct packed {
		logic wr;
		logic rd;
		logic [EPFR_ADDR_W-1:0] addr;
		logic [31:0] wdata;
	} epfr_req_s;

endpackage : epfr_pkg

// ---- rtl/epfr_record.sv ----
// One first-fault record register, instantiated once per engine
module epfr_record (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic fault_i,
	input wire epfr_pkg::epfr_fault_s fault_info_i,
	input wire logic sw_wr_i,
	input wire logic [31:0] sw_wdata_i,
	output logic [31:0] record_o
);
	import epfr_pkg::*;

	logic [31:0] record_ff;
	logic [31:0] nxt_record;
	logic valid_w;
	logic sw_clear_w;
	logic capture_w;
	logic [31:0] fault_word_w;

	// ************************************************************
	// Next-value decode
	// ************************************************************
	assign valid_w = record_ff[EPFR_VALID_POS];
	// Clearing valid wipes the whole word; a write leaving valid set is
	// ignored so software cannot forge a record
	assign sw_clear_w = sw_wr_i && !sw_wdata_i[EPFR_VALID_POS];
	// A fault in the clearing cycle counts as the first one again
	assign capture_w = fault_i && (!valid_w || sw_clear_w);
	assign fault_word_w = {fault_info_i.vaddr,
		fault_info_i.table_sel,
		fault_info_i.requester_identifier,
		fault_info_i.fault_class,
		1'b1};
	assign nxt_record = capture_w ? fault_word_w :
		(sw_clear_w ? EPFR_RESET_VAL : record_ff);

	// Record storage
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			record_ff <= EPFR_RESET_VAL;
		end else begin
			record_ff <= nxt_record;
		end
	end

	assign record_o = record_ff;

	// ************************************************************
	// Checks
	// ************************************************************
	a_hold_locked: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		valid_w && !sw_clear_w |=> $stable(record_ff))
		else $error("Locked record changed");
	a_capture_first: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		fault_i && !valid_w |=> record_ff == $past(fault_word_w))
		else $error("First fault not captured");
	a_clear_zero: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		sw_clear_w && !fault_i |=> record_ff == EPFR_RESET_VAL)
		else $error("Clear left fields set");
	a_race_capture: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		sw_clear_w && fault_i && valid_w |=> record_ff[EPFR_VALID_POS])
		else $error("Fault lost in clear cycle");
	a_valid_sets: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		fault_i |=> record_ff[EPFR_VALID_POS])
		else $error("Valid not set after fault");
	a_table_bit: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		fault_i && !valid_w |=>
		record_ff[EPFR_TSEL_POS] == $past(fault_info_i.table_sel))
		else $error("Table select wrong");
	a_source_id: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		fault_i && !valid_w |=> record_ff[EPFR_REQUESTER_IDENTIFIER_LSB +:
		EPFR_REQUESTER_IDENTIFIER_W] == $past(fault_info_i.requester_identifier))
		else $error("Requester id wrong");
	a_class_bits: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		fault_i && !valid_w |=> record_ff[EPFR_CLASS_LSB +:
		$bits(epfr_class_e)] == $past(fault_info_i.fault_class))
		else $error("Fault class wrong");
	a_reset_zero: assert property (@(posedge core_clk_i)
		rst_i |=> record_ff == EPFR_RESET_VAL)
		else $error("Record not zero after reset");

endmodule : epfr_record

// ---- rtl/epfr_top.sv ----
// Top of the engine page fault recorder: two records behind an MMIO port
module epfr_top (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire epfr_pkg::epfr_req_s req_i,
	output logic [31:0] rdata_o,
	output logic rvalid_o,
	input wire logic media_fault_i,
	input wire epfr_pkg::epfr_fault_s media_fault_info_i,
	input wire logic blit_fault_i,
	input wire epfr_pkg::epfr_fault_s blit_fault_info_i,
	output logic media_fault_valid_o,
	output logic blit_fault_valid_o
);
	import epfr_pkg::*;

	logic hit_media_w;
	logic hit_blit_w;
	logic [31:0] media_record_w;
	logic [31:0] blit_record_w;
	logic [31:0] nxt_rdata;
	logic [31:0] rdata_ff;
	logic rvalid_ff;
	logic media_wr_w;
	logic blit_wr_w;
	logic media_clear_w;
	logic blit_clear_w;
	logic hit_any_w;

	// ************************************************************
	// Address decode
	// ************************************************************
	// Each engine owns one word; unmapped reads return zero
	assign hit_media_w = req_i.addr == EPFR_MEDIA_OFS;
	assign hit_blit_w = req_i.addr == EPFR_BLIT_OFS;
	assign hit_any_w = hit_media_w || hit_blit_w;
	assign nxt_rdata = hit_media_w ? media_record_w :
		(hit_blit_w ? blit_record_w : EPFR_RESET_VAL);
	// Write strobes per record; the record itself decides whether a
	// write is an honoured clear or a refused attempt to set fields
	assign media_wr_w = req_i.wr && hit_media_w;
	assign blit_wr_w = req_i.wr && hit_blit_w;
	// Clearing writes, kept here so the checks below can see them
	assign media_clear_w = media_wr_w && !req_i.wdata[EPFR_VALID_POS];
	assign blit_clear_w = blit_wr_w && !req_i.wdata[EPFR_VALID_POS];

	// ************************************************************
	// Per-engine records
	// ************************************************************
	epfr_record u_media (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.fault_i(media_fault_i),
		.fault_info_i(media_fault_info_i),
		.sw_wr_i(media_wr_w),
		.sw_wdata_i(req_i.wdata),
		.record_o(media_record_w)
	);

	epfr_record u_blit (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.fault_i(blit_fault_i),
		.fault_info_i(blit_fault_info_i),
		.sw_wr_i(blit_wr_w),
		.sw_wdata_i(req_i.wdata),
		.record_o(blit_record_w)
	);

	// Registered read data, one cycle after the read strobe; it stays
	// put between reads so a slow poller always sees a settled word
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			rdata_ff <= EPFR_RESET_VAL;
			rvalid_ff <= 1'b0;
		end else begin
			rdata_ff <= req_i.rd ? nxt_rdata : rdata_ff;
			rvalid_ff <= req_i.rd;
		end
	end

	assign rdata_o = rdata_ff;
	assign rvalid_o = rvalid_ff;
	assign media_fault_valid_o = media_record_w[EPFR_VALID_POS];
	assign blit_fault_valid_o = blit_record_w[EPFR_VALID_POS];

	// ************************************************************
	// Checks
	// ************************************************************
	// These watch the records from outside, through the read and valid
	// ports; each record checks its own next-value logic as well
	// Named steps of a capture: an armed engine sees a report, a clear
	// meets a report, and the word that follows either of them
	sequence s_media_armed_fault;
		media_fault_i && !media_fault_valid_o;
	endsequence
	sequence s_media_cleared_fault;
		media_fault_i && media_clear_w;
	endsequence
	sequence s_media_took_report;
		media_fault_valid_o && media_record_w[EPFR_CLASS_LSB +:
			$bits(epfr_fault_s)] == $past(media_fault_info_i);
	endsequence
	sequence s_blit_armed_fault;
		blit_fault_i && !blit_fault_valid_o;
	endsequence
	sequence s_blit_cleared_fault;
		blit_fault_i && blit_clear_w;
	endsequence
	sequence s_blit_took_report;
		blit_fault_valid_o && blit_record_w[EPFR_CLASS_LSB +:
			$bits(epfr_fault_s)] == $past(blit_fault_info_i);
	endsequence

	// A report to an armed engine lands whole in the next word
	a_media_first: assert property (@(posedge core_clk_i)
		disable iff (rst_i) s_media_armed_fault |=> s_media_took_report)
		else $error("Media first fault not captured");
	a_blit_first: assert property (@(posedge core_clk_i)
		disable iff (rst_i) s_blit_armed_fault |=> s_blit_took_report)
		else $error("Blitter first fault not captured");

	// Set wins: a report meeting a clear is kept, not dropped
	a_media_race: assert property (@(posedge core_clk_i)
		disable iff (rst_i) s_media_cleared_fault |=> s_media_took_report)
		else $error("Media fault lost in clear cycle");
	a_blit_race: assert property (@(posedge core_clk_i)
		disable iff (rst_i) s_blit_cleared_fault |=> s_blit_took_report)
		else $error("Blitter fault lost in clear cycle");

	// Any report leaves the valid output set one cycle later
	a_media_valid_sets: assert property (@(posedge core_clk_i)
		disable iff (rst_i) media_fault_i |=> media_fault_valid_o)
		else $error("Media valid not set after fault");
	a_blit_valid_sets: assert property (@(posedge core_clk_i)
		disable iff (rst_i) blit_fault_i |=> blit_fault_valid_o)
		else $error("Blitter valid not set after fault");

	// A locked record ignores later reports and refused writes
	a_media_locked: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		media_fault_valid_o && !media_clear_w |=> $stable(media_record_w))
		else $error("Media record changed while locked");
	a_blit_locked: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		blit_fault_valid_o && !blit_clear_w |=> $stable(blit_record_w))
		else $error("Blitter record changed while locked");

	// A clear with no report in the same cycle leaves an all-zero word
	a_media_clear: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		media_clear_w && !media_fault_i |=> media_record_w == EPFR_RESET_VAL)
		else $error("Media clear left fields set");
	a_blit_clear: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		blit_clear_w && !blit_fault_i |=> blit_record_w == EPFR_RESET_VAL)
		else $error("Blitter clear left fields set");

	// Software cannot forge a record by writing the valid bit as one
	a_media_no_forge: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		media_wr_w && req_i.wdata[EPFR_VALID_POS] && !media_fault_i |=>
		$stable(media_record_w))
		else $error("Media record written by software");
	a_blit_no_forge: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		blit_wr_w && req_i.wdata[EPFR_VALID_POS] && !blit_fault_i |=>
		$stable(blit_record_w))
		else $error("Blitter record written by software");

	// Engines never disturb each other's record
	a_engine_isolate: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		!blit_fault_i && !blit_wr_w |=>
		$stable(blit_record_w))
		else $error("Blitter record changed without cause");
	a_media_isolate: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		!media_fault_i && !media_wr_w |=>
		$stable(media_record_w))
		else $error("Media record changed without cause");

	// Read path: one word per strobe, one cycle later
	a_read_media: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		req_i.rd && hit_media_w |=> rvalid_o &&
		rdata_o == $past(media_record_w))
		else $error("Media read data wrong");
	a_read_blit: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		req_i.rd && hit_blit_w |=> rvalid_o &&
		rdata_o == $past(blit_record_w))
		else $error("Blitter read data wrong");

	// Unmapped reads see zero, so a stray address cannot leak a record
	a_unmapped_zero: assert property (@(posedge core_clk_i)
		disable iff (rst_i)
		req_i.rd && !hit_any_w |=> rvalid_o && rdata_o == EPFR_RESET_VAL)
		else $error("Unmapped read returned data");

	// Read valid is a one-cycle pulse; read data stands until next read
	a_rvalid_after: assert property (@(posedge core_clk_i)
		disable iff (rst_i) req_i.rd |=> rvalid_o)
		else $error("Read valid missing");
	a_rvalid_pulse: assert property (@(posedge core_clk_i)
		disable iff (rst_i) !req_i.rd |=> !rvalid_o)
		else $error("Read valid without a read");
	a_rdata_hold: assert property (@(posedge core_clk_i)
		disable iff (rst_i) !req_i.rd |=> $stable(rdata_o))
		else $error("Read data changed between reads");

	// Reset leaves every output at its idle value
	a_reset_outputs: assert property (@(posedge core_clk_i)
		rst_i |=> rdata_o == EPFR_RESET_VAL && !rvalid_o &&
		!media_fault_valid_o && !blit_fault_valid_o)
		else $error("Outputs not idle after reset");

endmodule : epfr_top

// ---- tb/epfr_bench.sv ----
// Self-checking bench for the engine page fault recorders
module epfr_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import epfr_pkg::*;
	logic core_clk_i, rst_i, rvalid, m_f, b_f, m_v, b_v;
	logic [1:0] go;
	logic [31:0] rdata;
	logic [31:0] exp_rec [2];
	epfr_req_s req;
	epfr_fault_s info, m_i, b_i;
	int err_count = 0;
	int checked = 0;
	int seed = 32'h50ffebc6;

	epfr_fault_src src_m (.clk_i(core_clk_i), .go_i(go[0]),
		.info_i(info), .fault_o(m_f), .info_o(m_i));
	epfr_fault_src src_b (.clk_i(core_clk_i), .go_i(go[1]),
		.info_i(info), .fault_o(b_f), .info_o(b_i));
	epfr_top dut (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.req_i(req),
		.rdata_o(rdata),
		.rvalid_o(rvalid),
		.media_fault_i(m_f),
		.media_fault_info_i(m_i),
		.blit_fault_i(b_f),
		.blit_fault_info_i(b_i),
		.media_fault_valid_o(m_v),
		.blit_fault_valid_o(b_v)
	);

	// 10 MHz core clock
	initial begin
		core_clk_i = 1'b0;
		forever #50 core_clk_i = ~core_clk_i;
	end

	function automatic logic [19:0] ofs(int e);
		return e ? EPFR_BLIT_OFS : EPFR_MEDIA_OFS;
	endfunction : ofs

	// Captured word: the report fields with the valid bit set
	function automatic logic [31:0] word(epfr_fault_s f);
		return {f, 1'b1};
	endfunction : word

	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic rd(logic [19:0] a, logic [31:0] exp);
		@(posedge core_clk_i);
		req.rd <= 1'b1;
		req.addr <= a;
		@(posedge core_clk_i);
		req.rd <= 1'b0;
		#1 check("rvalid", {31'h0, rvalid}, 32'h1);
		check("rdata", rdata, exp);
	endtask : rd

	task automatic wr(logic [19:0] a, logic [31:0] d);
		@(posedge core_clk_i);
		req.wr <= 1'b1;
		req.addr <= a;
		req.wdata <= d;
		@(posedge core_clk_i);
		req.wr <= 1'b0;
	endtask : wr

	// One fault report; with race a clear lands on the capture edge
	task automatic fault(int e, int c, bit race);
		logic [31:0] r;
		epfr_fault_s nf;
		r = $random(seed);
		nf = r[30:0];
		nf.fault_class = epfr_class_e'(c[1:0]);
		@(posedge core_clk_i);
		info <= nf;
		go[e] <= 1'b1;
		@(posedge core_clk_i);
		go[e] <= 1'b0;
		req.wr <= race;
		req.addr <= ofs(e);
		req.wdata <= 32'h0;
		@(posedge core_clk_i);
		req.wr <= 1'b0;
		@(posedge core_clk_i);
		if (race || !exp_rec[e][0]) exp_rec[e] = word(nf);
	endtask : fault

	task automatic finish_test();
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : finish_test

	// Main sequence: every class, lock, refused write, clear, race
	initial begin
		rst_i <= 1'b1;
		go <= 2'h0;
		req <= '0;
		info <= '0;
		exp_rec = '{default: '0};
		repeat (5) @(posedge core_clk_i);
		rst_i <= 1'b0;
		for (int e = 0; e < 2; e++) rd(ofs(e), 32'h0);
		for (int k = 0; k < 4; k++) begin
			for (int e = 0; e < 2; e++) fault(e, k + e, 1'b0);
			for (int e = 0; e < 2; e++) fault(e, k + 1, 1'b0);
			#1 check("valid", {30'h0, b_v, m_v},
				{30'h0, exp_rec[1][0], exp_rec[0][0]});
			for (int e = 0; e < 2; e++) begin
				rd(ofs(e), exp_rec[e]);
				wr(ofs(e), 32'hffff_ffff);
				rd(ofs(e), exp_rec[e]);
				wr(ofs(e), 32'h0);
				exp_rec[e] = 32'h0;
				rd(ofs(e), 32'h0);
			end
		end
		rd(20'h04198, 32'h0);
		for (int e = 0; e < 2; e++) begin
			fault(e, 2, 1'b0);
			fault(e, 1, 1'b1);
			rd(ofs(e), exp_rec[e]);
		end
		finish_test();
	end

	// Watchdog: the sequence needs well under 3000 cycles
	initial begin
		#(3000 * 100);
		err_count++;
		finish_test();
	end
endmodule : epfr_bench

// ---- tb/epfr_fault_src.sv ----
// Partner model: translation unit that reports one fault per request
module epfr_fault_src (
	input wire logic clk_i,
	input wire logic go_i,
	input wire epfr_pkg::epfr_fault_s info_i,
	output logic fault_o,
	output epfr_pkg::epfr_fault_s info_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import epfr_pkg::*;
	// Info off the strobe is junk, so sampling it at the wrong time shows
	always_ff @(posedge clk_i) begin
		fault_o <= go_i;
		info_o <= go_i ? info_i : ~info_i;
	end
endmodule : epfr_fault_src
